// ==== hw/cirs_pkg.sv ====
// constants shared by the reset-cause and interrupt event block
package cirs_pkg;
  // ==========================================================================
  // register map on the plain register port
  localparam logic [3:0] CIRS_ADDR_STATUS = 4'h0;
  localparam logic [3:0] CIRS_ADDR_POWER_CONTROL_FLAGS   = 4'h1;
  localparam logic [3:0] CIRS_ADDR_INTCTL = 4'h2;
  localparam logic [3:0] CIRS_ADDR_PREQ1  = 4'h3;
  localparam logic [3:0] CIRS_ADDR_PREQ2  = 4'h4;
  localparam logic [3:0] CIRS_ADDR_PEN1   = 4'h5;
  localparam logic [3:0] CIRS_ADDR_PEN2   = 4'h6;
  localparam logic [3:0] CIRS_ADDR_OPTCTL = 4'h7;
  localparam logic [3:0] CIRS_ADDR_ANALOG_SELECT_REG  = 4'h8;
  // ==========================================================================
  // field positions
  localparam int CIRS_ST_TO       = 4;
  localparam int CIRS_ST_PD       = 3;
  localparam int CIRS_PC_OT       = 2;
  localparam int CIRS_PC_POR      = 1;
  localparam int CIRS_IC_GIE      = 7;
  localparam int CIRS_IC_PERIPHERAL_IRQ_ENABLE     = 6;
  localparam int CIRS_IC_T0IE     = 5;
  localparam int CIRS_IC_EXTIE    = 4;
  localparam int CIRS_IC_PCHIE    = 3;
  localparam int CIRS_IC_T0IF     = 2;
  localparam int CIRS_IC_EXTIF    = 1;
  localparam int CIRS_IC_PCHIF    = 0;
  localparam int CIRS_OPT_EDGE    = 6;
  // implemented bit masks of the peripheral request/enable, status and power control registers
  localparam logic [7:0] CIRS_PREQ1_MASK = 8'h73;
  localparam logic [7:0] CIRS_PREQ2_MASK = 8'hb2;
  localparam logic [7:0] CIRS_STATUS_MASK = 8'hff;
  localparam logic [7:0] CIRS_POWER_CONTROL_FLAGS_MASK  = 8'h06;
  // ==========================================================================
  // reset values
  localparam logic [7:0]  CIRS_STATUS_POR = 8'h18;
  localparam logic [12:0] CIRS_RESET_VEC  = 13'h0000;
  localparam logic [12:0] CIRS_IRQ_VEC    = 13'h0004;
  localparam logic [7:0]  CIRS_ANALOG_SELECT_REG_RST  = 8'h01;
  // instruction cycle = four Q phases of sys_clk
  localparam logic [1:0]  CIRS_Q1 = 2'h0;
  localparam logic [1:0]  CIRS_Q4 = 2'h3;
  // ==========================================================================
  typedef enum logic [1:0] {
    CIRS_RUN    = 2'b00,
    CIRS_SLEEP  = 2'b01,
    CIRS_WAKE   = 2'b10
  } cirs_state_t;
endpackage : cirs_pkg

// ==== hw/cirs_edge_detect.sv ====
// edge detector for the external interrupt pin
`timescale 1ns/1ps
module cirs_edge_detect
  import cirs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pinIn,
  input  wire logic risingSel,
  input  wire logic digitalEn,
  output logic      edgePulse
);
  logic pinLast_ff;
  logic nxt_pinLast;
  logic nxt_edgePulse;

  always_comb begin
    // an analog-configured pin reads zero, so it can never produce an edge
    nxt_pinLast   = pinIn & digitalEn;
    nxt_edgePulse = risingSel ? (nxt_pinLast & ~pinLast_ff)
                              : (~nxt_pinLast & pinLast_ff);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinLast_ff <= 1'b0;
      edgePulse  <= 1'b0;
    end else begin
      pinLast_ff <= nxt_pinLast;
      edgePulse  <= nxt_edgePulse;
    end
  end
endmodule : cirs_edge_detect

// ==== hw/cirs_qphase.sv ====
// instruction-cycle phase counter, four clocks per cycle
`timescale 1ns/1ps
module cirs_qphase
  import cirs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  output logic [1:0]      qPhase
);
  logic [1:0] nxt_qPhase;

  always_comb begin
    nxt_qPhase = qPhase + 2'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      qPhase <= CIRS_Q1;
    end else begin
      qPhase <= nxt_qPhase;
    end
  end
endmodule : cirs_qphase

// ==== hw/cirs_core.sv ====
// reset-cause recording and interrupt gathering for the processor core
// ============================================================================
// What this block does
// - every reset except master clear outside sleep updates cause bits in status and power control registers
// - power-on: vector zero, timeout and powerdown set, power-on flag cleared
// - watchdog: reset clears timeout; in sleep wakes, clears both, continues
// - interrupt wake: timeout set, powerdown cleared, vector if global enable
// - master clear: vector zero; flags kept, or in sleep timeout set, pd clear
// - unimplemented status bits read zero
// - overtemperature flag bit 2 reads zero after that reset; software sets it
// - power-on flag bit 1 reads zero after power-on; software sets it
// - power control bits 7-3 and 0 read zero
// - one request flag per source across control and peripheral registers
// - global enable gates all, individual enables mask, reset clears global
// - taking an interrupt clears global enable, pushes return, loads vector
// - flags set regardless of any enable
// - with global enable clear, events set flags; enabled ones still wake from sleep
// - interrupt pending while global enable is cleared waits until re-enabled
// - return from service pops address, restores context, sets global enable
// - pin event to vector takes three to four instruction cycles; here seven to ten sys_clk cycles
// - external pin edge selectable rising or falling, sets external flag
// - external pin wakes from sleep only if its enable is set
// - analog-configured pin reads zero and never interrupts
// - external flag settable Q4 through Q1, sampled at every Q1
// - control register layout: gie peripheral_irq_enable t0ie exte pche t0if extf pchf
// - peripheral sources also need the peripheral enable
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cirs_core
  import cirs_pkg::*;
#(
  parameter int PC_W = 13
)(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            porEvent,
  input  wire logic            mclrEvent,
  input  wire logic            wdtEvent,
  input  wire logic            otEvent,
  input  wire logic            sleepEnter,
  input  wire logic            retFromIsr,
  input  wire logic            extIrqPin,
  input  wire logic            tmr0Ovf,
  input  wire logic            pinChange,
  input  wire logic [7:0]      periphReq1,
  input  wire logic [7:0]      periphReq2,
  input  wire logic [PC_W-1:0] pcNow,
  input  wire logic [3:0]      regAddr,
  input  wire logic [7:0]      regWrData,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  output logic [7:0]           regRdData,
  output logic                 pcLoad,
  output logic [PC_W-1:0]      pcTarget,
  output logic                 stackPush,
  output logic                 ctxRestore,
  output logic                 coreRestart,
  output logic                 sleeping
);
  // ==========================================================================
  // helpers
  logic [1:0] qPhase;
  logic       extEdge;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] power_control_flags_ff, nxt_power_control_flags;
  logic [7:0] intctl_ff, nxt_intctl;
  logic [7:0] preq1_ff, nxt_preq1;
  logic [7:0] preq2_ff, nxt_preq2;
  logic [7:0] pen1_ff, nxt_pen1;
  logic [7:0] pen2_ff, nxt_pen2;
  logic [7:0] opt_ff, nxt_opt;
  logic [7:0] analog_select_reg_ff, nxt_analog_select_reg;
  logic       extLatch_ff, nxt_extLatch;
  logic       pend_ff, nxt_pend;
  cirs_state_t state_ff, nxt_state;
  logic [7:0] nxt_rdData;
  logic       nxt_pcLoad, nxt_stackPush, nxt_ctxRestore, nxt_restart;
  logic [PC_W-1:0] nxt_pcTarget;
  logic       irqWanted;
  logic       wakeWanted;

  function automatic logic wrHit(input logic [3:0] a);
    wrHit = regWrite && (regAddr == a);
  endfunction : wrHit

  cirs_qphase u_qphase (
    .sys_clk (sys_clk),
    .rst     (rst),
    .qPhase  (qPhase)
  );

  cirs_edge_detect u_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pinIn     (extIrqPin),
    .risingSel (opt_ff[CIRS_OPT_EDGE]),
    .digitalEn (~analog_select_reg_ff[0]),
    .edgePulse (extEdge)
  );

  // ==========================================================================
  // request gathering
  always_comb begin
    // an edge seen in Q2/Q3 is held and posted at the next Q4 window
    nxt_extLatch = (extLatch_ff | extEdge) & ~((qPhase == CIRS_Q4) || (qPhase == CIRS_Q1));
    // write data first, hardware set last so that a set beats a clear
    nxt_intctl = intctl_ff;
    nxt_preq1  = preq1_ff;
    nxt_preq2  = preq2_ff;
    nxt_pen1   = pen1_ff;
    nxt_pen2   = pen2_ff;
    nxt_opt    = opt_ff;
    nxt_analog_select_reg  = analog_select_reg_ff;
    if (wrHit(CIRS_ADDR_INTCTL)) nxt_intctl = regWrData;
    if (wrHit(CIRS_ADDR_PREQ1))  nxt_preq1  = regWrData & CIRS_PREQ1_MASK;
    if (wrHit(CIRS_ADDR_PREQ2))  nxt_preq2  = regWrData & CIRS_PREQ2_MASK;
    if (wrHit(CIRS_ADDR_PEN1))   nxt_pen1   = regWrData & CIRS_PREQ1_MASK;
    if (wrHit(CIRS_ADDR_PEN2))   nxt_pen2   = regWrData & CIRS_PREQ2_MASK;
    if (wrHit(CIRS_ADDR_OPTCTL)) nxt_opt    = regWrData;
    if (wrHit(CIRS_ADDR_ANALOG_SELECT_REG))  nxt_analog_select_reg  = regWrData;
    if (tmr0Ovf)   nxt_intctl[CIRS_IC_T0IF]  = 1'b1;
    if (pinChange) nxt_intctl[CIRS_IC_PCHIF] = 1'b1;
    if ((extEdge || extLatch_ff) && ((qPhase == CIRS_Q4) || (qPhase == CIRS_Q1)))
      nxt_intctl[CIRS_IC_EXTIF] = 1'b1;
    nxt_preq1 = nxt_preq1 | (periphReq1 & CIRS_PREQ1_MASK);
    nxt_preq2 = nxt_preq2 | (periphReq2 & CIRS_PREQ2_MASK);
    if (retFromIsr) nxt_intctl[CIRS_IC_GIE] = 1'b1;
    if (nxt_pcLoad && (state_ff != CIRS_SLEEP || intctl_ff[CIRS_IC_GIE]))
      nxt_intctl[CIRS_IC_GIE] = nxt_pcTarget != CIRS_IRQ_VEC ? nxt_intctl[CIRS_IC_GIE]
                                                             : 1'b0;
  end

  always_comb begin
    wakeWanted =
      (intctl_ff[CIRS_IC_EXTIE] & intctl_ff[CIRS_IC_EXTIF]) |
      (intctl_ff[CIRS_IC_T0IE]  & intctl_ff[CIRS_IC_T0IF])  |
      (intctl_ff[CIRS_IC_PCHIE] & intctl_ff[CIRS_IC_PCHIF]) |
      (intctl_ff[CIRS_IC_PERIPHERAL_IRQ_ENABLE] &
       (|(preq1_ff & pen1_ff) | |(preq2_ff & pen2_ff)));
    // gie sampled as a register, so a write clearing it blocks the next entry
    irqWanted = wakeWanted & intctl_ff[CIRS_IC_GIE] & ~(wrHit(CIRS_ADDR_INTCTL)
                & ~regWrData[CIRS_IC_GIE]);
  end

  // ==========================================================================
  // reset causes and core sequencing
  always_comb begin
    nxt_status     = status_ff;
    nxt_power_control_flags       = power_control_flags_ff;
    nxt_state      = state_ff;
    nxt_pcLoad     = 1'b0;
    nxt_pcTarget   = pcTarget;
    nxt_stackPush  = 1'b0;
    nxt_ctxRestore = retFromIsr;
    nxt_restart    = 1'b0;
    nxt_pend       = 1'b0;
    if (wrHit(CIRS_ADDR_STATUS))
      nxt_status = (regWrData & CIRS_STATUS_MASK & 8'he7) | (status_ff & 8'h18);
    if (wrHit(CIRS_ADDR_POWER_CONTROL_FLAGS)) nxt_power_control_flags = regWrData & CIRS_POWER_CONTROL_FLAGS_MASK;
    // entry is decided at Q1 and the vector issued one Q1 later
    if (qPhase == CIRS_Q1) begin
      nxt_pend = irqWanted && state_ff == CIRS_RUN;
      if (pend_ff && intctl_ff[CIRS_IC_GIE]) begin
        nxt_pcLoad    = 1'b1;
        nxt_pcTarget  = CIRS_IRQ_VEC;
        nxt_stackPush = 1'b1;
      end
    end else begin
      nxt_pend = pend_ff;
    end
    case (state_ff)
      CIRS_RUN: begin
        if (sleepEnter) begin
          nxt_state = CIRS_SLEEP;
          nxt_status[CIRS_ST_TO] = 1'b1;
          nxt_status[CIRS_ST_PD] = 1'b0;
        end
      end
      CIRS_SLEEP: begin
        if (wdtEvent) begin
          nxt_state = CIRS_RUN;
          nxt_status[CIRS_ST_TO] = 1'b0;
          nxt_status[CIRS_ST_PD] = 1'b0;
        end else if (wakeWanted) begin
          nxt_state = CIRS_WAKE;
          nxt_status[CIRS_ST_TO] = 1'b1;
          nxt_status[CIRS_ST_PD] = 1'b0;
        end
      end
      CIRS_WAKE: begin
        // next instruction runs, then the vector at its end
        if (qPhase == CIRS_Q4) begin
          nxt_state = CIRS_RUN;
          if (intctl_ff[CIRS_IC_GIE]) begin
            nxt_pcLoad    = 1'b1;
            nxt_pcTarget  = CIRS_IRQ_VEC;
            nxt_stackPush = 1'b1;
          end
        end
      end
      default: nxt_state = CIRS_RUN;
    endcase
    if (mclrEvent || (wdtEvent && state_ff != CIRS_SLEEP) || otEvent) begin
      nxt_restart  = 1'b1;
      nxt_pcLoad   = 1'b1;
      nxt_pcTarget = CIRS_RESET_VEC;
      nxt_stackPush = 1'b0;
      nxt_pend     = 1'b0;
      nxt_state    = CIRS_RUN;
      nxt_status[7:5] = 3'h0;
      if (otEvent) nxt_power_control_flags[CIRS_PC_OT] = 1'b0;
      if (wdtEvent && state_ff != CIRS_SLEEP) nxt_status[CIRS_ST_TO] = 1'b0;
      if (mclrEvent && state_ff != CIRS_RUN) begin
        nxt_status[CIRS_ST_TO] = 1'b1;
        nxt_status[CIRS_ST_PD] = 1'b0;
      end
    end
  end

  always_comb begin
    nxt_rdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        CIRS_ADDR_STATUS: nxt_rdData = status_ff & CIRS_STATUS_MASK;
        CIRS_ADDR_POWER_CONTROL_FLAGS:   nxt_rdData = power_control_flags_ff & CIRS_POWER_CONTROL_FLAGS_MASK;
        CIRS_ADDR_INTCTL: nxt_rdData = intctl_ff;
        CIRS_ADDR_PREQ1:  nxt_rdData = preq1_ff;
        CIRS_ADDR_PREQ2:  nxt_rdData = preq2_ff;
        CIRS_ADDR_PEN1:   nxt_rdData = pen1_ff;
        CIRS_ADDR_PEN2:   nxt_rdData = pen2_ff;
        CIRS_ADDR_OPTCTL: nxt_rdData = opt_ff;
        CIRS_ADDR_ANALOG_SELECT_REG:  nxt_rdData = analog_select_reg_ff;
        default:          nxt_rdData = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // registers; rst is the power-on reset path
  always_ff @(posedge sys_clk) begin
    if (rst || porEvent) begin
      status_ff   <= CIRS_STATUS_POR;
      // a later power-on event keeps the overtemperature cause; of the two power-on paths only rst clears it
      power_control_flags_ff     <= rst ? 8'h00 : (power_control_flags_ff & 8'h04);
      intctl_ff   <= 8'h00;
      preq1_ff    <= 8'h00;
      preq2_ff    <= 8'h00;
      pen1_ff     <= 8'h00;
      pen2_ff     <= 8'h00;
      opt_ff      <= 8'h00;
      analog_select_reg_ff    <= CIRS_ANALOG_SELECT_REG_RST;
      extLatch_ff <= 1'b0;
      pend_ff     <= 1'b0;
      state_ff    <= CIRS_RUN;
      regRdData   <= 8'h00;
      pcLoad      <= 1'b1;
      pcTarget    <= CIRS_RESET_VEC;
      stackPush   <= 1'b0;
      ctxRestore  <= 1'b0;
      coreRestart <= 1'b1;
      sleeping    <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      power_control_flags_ff     <= nxt_power_control_flags;
      intctl_ff   <= (nxt_restart ? (nxt_intctl & 8'h7f) : nxt_intctl);
      preq1_ff    <= nxt_preq1;
      preq2_ff    <= nxt_preq2;
      pen1_ff     <= nxt_pen1;
      pen2_ff     <= nxt_pen2;
      opt_ff      <= nxt_opt;
      analog_select_reg_ff    <= nxt_analog_select_reg;
      extLatch_ff <= nxt_extLatch;
      pend_ff     <= nxt_pend;
      state_ff    <= nxt_state;
      regRdData   <= nxt_rdData;
      pcLoad      <= nxt_pcLoad;
      pcTarget    <= nxt_pcTarget;
      stackPush   <= nxt_stackPush;
      ctxRestore  <= nxt_ctxRestore;
      coreRestart <= nxt_restart;
      sleeping    <= (nxt_state == CIRS_SLEEP);
    end
  end
endmodule : cirs_core

// ==== testbench/cirs_core_sva.sv ====
// assertion checker for the reset-cause and interrupt event block
`timescale 1ns/1ps
module cirs_core_sva
  import cirs_pkg::*;
#(
  parameter int PC_W = 13
)(
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic            mclrEvent,
  input wire logic            wdtEvent,
  input wire logic            otEvent,
  input wire logic            retFromIsr,
  input wire logic [3:0]      regAddr,
  input wire logic            regRead,
  input wire logic [7:0]      regRdData,
  input wire logic            pcLoad,
  input wire logic [PC_W-1:0] pcTarget,
  input wire logic            stackPush,
  input wire logic            ctxRestore,
  input wire logic            coreRestart,
  input wire logic            sleeping
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // register port
  chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  chk_power_control_flags_rsvd: assert property ($past(regRead) && $past(regAddr) == CIRS_ADDR_POWER_CONTROL_FLAGS
    |-> regRdData[7:3] == 5'h00 && !regRdData[0])
    else $error("power control reserved bits not zero");
  chk_unmapped_zero: assert property ($past(regRead) && $past(regAddr) > CIRS_ADDR_ANALOG_SELECT_REG
    |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // ==========================================================================
  // vectoring
  chk_push_vec: assert property (stackPush |-> pcLoad && pcTarget == CIRS_IRQ_VEC)
    else $error("push without irq vector load");
  chk_push_once: assert property (stackPush |=> !stackPush)
    else $error("push longer than one cycle");
  chk_restart_vec: assert property (coreRestart |-> pcLoad && pcTarget == CIRS_RESET_VEC)
    else $error("restart without zero vector");
  chk_master_clear_restart: assert property (mclrEvent |-> ##[1:2] coreRestart)
    else $error("master clear did not restart");
  chk_wdt_restart: assert property (wdtEvent && !sleeping |-> ##[1:2] coreRestart)
    else $error("watchdog did not restart");
  chk_wdt_wake: assert property (wdtEvent && sleeping |=> !coreRestart [*2])
    else $error("watchdog in sleep restarted");
  chk_ot_restart: assert property (otEvent |-> ##[1:2] coreRestart)
    else $error("overtemperature did not restart");
  chk_ret_ctx: assert property (retFromIsr |=> ctxRestore)
    else $error("return without context restore");
  cov_push: cover property (stackPush);
  cov_ctx: cover property (ctxRestore);
  cov_wake: cover property ($fell(sleeping));
endmodule : cirs_core_sva

bind cirs_core cirs_core_sva #(.PC_W(PC_W)) u_sva (
  .sys_clk, .rst, .mclrEvent, .wdtEvent, .otEvent, .retFromIsr, .regAddr, .regRead,
  .regRdData, .pcLoad, .pcTarget, .stackPush, .ctxRestore, .coreRestart, .sleeping
);

// ==== testbench/cirs_seq_model.sv ====
// behavioural processor sequencer with program counter and return stack
`timescale 1ns/1ps
module cirs_seq_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        pcLoad,
  input  wire logic [12:0] pcTarget,
  input  wire logic        stackPush,
  input  wire logic        ctxRestore,
  output logic      [12:0] pcNow,
  output logic      [7:0]  pushCnt
);
  logic [12:0] stk [$];
  // one fetch per clock keeps the model short; only the order matters here
  always @(posedge sys_clk) begin
    if (rst) begin
      pcNow <= 13'h0000;
      pushCnt <= 8'h00;
    end else begin
      if (stackPush) begin
        stk.push_back(pcNow);
        pushCnt <= pushCnt + 8'h01;
      end
      if (pcLoad) pcNow <= pcTarget;
      else if (ctxRestore && stk.size() > 0) pcNow <= stk.pop_back();
      else pcNow <= pcNow + 13'h0001;
    end
  end
endmodule : cirs_seq_model

// ==== testbench/cirs_core_tb.sv ====
// self-checking bench for the reset-cause and interrupt event block
`timescale 1ns/1ps
module cirs_core_tb
  import cirs_pkg::*;
;
  localparam int LAT = 20;
  logic        sys_clk, rst, extIrqPin, regWrite, regRead;
  logic [7:0]  evs, preq1, preq2, regWrData, regRdData, got, r, pushCnt, base;
  logic [3:0]  regAddr;
  logic [12:0] pcNow, pcTarget;
  logic        pcLoad, stackPush, ctxRestore, coreRestart, sleeping;
  int          n_fail, compares, seed;

  cirs_core dut (
    .sys_clk, .rst, .porEvent(evs[0]), .mclrEvent(evs[1]), .wdtEvent(evs[2]),
    .otEvent(evs[3]), .sleepEnter(evs[4]), .retFromIsr(evs[5]), .extIrqPin,
    .tmr0Ovf(evs[6]), .pinChange(evs[7]), .periphReq1(preq1), .periphReq2(preq2),
    .pcNow, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pcLoad,
    .pcTarget, .stackPush, .ctxRestore, .coreRestart, .sleeping
  );
  cirs_seq_model model (
    .sys_clk, .rst, .pcLoad, .pcTarget, .stackPush, .ctxRestore, .pcNow, .pushCnt
  );
  // ==========================================================================
  // helpers
  function automatic logic [7:0] intctl(input logic g, input logic [2:0] en,
                                        input logic [2:0] fl);
    return {g, 1'b0, en, fl};
  endfunction : intctl
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 got = regRdData;
    @(posedge sys_clk);
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask : rdc
  task automatic ev(input int k);
    evs[k] <= 1'b1;
    @(posedge sys_clk);
    evs <= 8'h00;
    repeat (8) @(posedge sys_clk);
  endtask : ev
  task automatic pin(input logic v);
    extIrqPin <= v;
    repeat (8) @(posedge sys_clk);
  endtask : pin
  // absence needs the full window, so the wait is fixed at the latency bound
  task automatic push(input logic e);
    repeat (LAT) @(posedge sys_clk);
    chk({7'h00, pushCnt != base}, {7'h00, e});
  endtask : push
  task automatic finish_test();
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end
  // ==========================================================================
  // scenarios
  initial begin
    rst = 1'b1;
    evs = 8'h00;
    preq1 = 8'h00;
    preq2 = 8'h00;
    extIrqPin = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    n_fail = 0;
    compares = 0;
    seed = 17;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(CIRS_ADDR_STATUS, CIRS_STATUS_POR);
    rdc(CIRS_ADDR_POWER_CONTROL_FLAGS, 8'h00);
    rdc(CIRS_ADDR_INTCTL, 8'h00);
    rdc(4'hf, 8'h00);
    wr(CIRS_ADDR_POWER_CONTROL_FLAGS, 8'hff);
    rdc(CIRS_ADDR_POWER_CONTROL_FLAGS, 8'h06);
    ev(3);
    rdc(CIRS_ADDR_POWER_CONTROL_FLAGS, 8'h02);
    ev(2);
    rd(CIRS_ADDR_STATUS);
    chk({3'h0, got[7:3]}, 8'h01);
    ev(1);
    rd(CIRS_ADDR_STATUS);
    chk({3'h0, got[7:3]}, 8'h01);
    ev(4);
    chk({7'h00, sleeping}, 8'h01);
    ev(1);
    rd(CIRS_ADDR_STATUS);
    chk({3'h0, got[7:3]}, 8'h02);
    ev(4);
    ev(2);
    rd(CIRS_ADDR_STATUS);
    chk({6'h00, got[4:3]}, 8'h00);
    chk({7'h00, sleeping}, 8'h00);
    // wake by the pin edge with global enable set
    wr(CIRS_ADDR_ANALOG_SELECT_REG, 8'h00);
    wr(CIRS_ADDR_OPTCTL, 8'h40);
    wr(CIRS_ADDR_INTCTL, intctl(1'b1, 3'b010, 3'b000));
    ev(4);
    base = pushCnt;
    extIrqPin <= 1'b1;
    push(1'b1);
    rd(CIRS_ADDR_STATUS);
    chk({6'h00, got[4:3]}, 8'h02);
    rdc(CIRS_ADDR_INTCTL, intctl(1'b0, 3'b010, 3'b010));
    wr(CIRS_ADDR_INTCTL, intctl(1'b0, 3'b010, 3'b000));
    ev(5);
    rdc(CIRS_ADDR_INTCTL, intctl(1'b1, 3'b010, 3'b000));
    pin(1'b0);
    rdc(CIRS_ADDR_INTCTL, intctl(1'b1, 3'b010, 3'b000));
    wr(CIRS_ADDR_INTCTL, 8'h00);
    for (int e = 0; e < 2; e++) begin
      pin(~e[0]);
      wr(CIRS_ADDR_OPTCTL, {1'b0, e[0], 6'h00});
      wr(CIRS_ADDR_INTCTL, 8'h00);
      pin(e[0]);
      rdc(CIRS_ADDR_INTCTL, intctl(1'b0, 3'b000, 3'b010));
    end
    wr(CIRS_ADDR_ANALOG_SELECT_REG, 8'h01);
    wr(CIRS_ADDR_INTCTL, 8'h00);
    pin(1'b0);
    pin(1'b1);
    rdc(CIRS_ADDR_INTCTL, 8'h00);
    // pending while disabled, taken once enabled
    wr(CIRS_ADDR_INTCTL, intctl(1'b0, 3'b001, 3'b000));
    base = pushCnt;
    ev(7);
    push(1'b0);
    rdc(CIRS_ADDR_INTCTL, intctl(1'b0, 3'b001, 3'b001));
    wr(CIRS_ADDR_INTCTL, intctl(1'b1, 3'b001, 3'b001));
    push(1'b1);
    wr(CIRS_ADDR_INTCTL, 8'h00);
    // peripheral source needs the peripheral enable
    wr(CIRS_ADDR_PEN1, 8'h01);
    preq1 <= 8'h01;
    @(posedge sys_clk);
    preq1 <= 8'h00;
    base = pushCnt;
    wr(CIRS_ADDR_INTCTL, 8'h80);
    push(1'b0);
    rdc(CIRS_ADDR_PREQ1, 8'h01);
    wr(CIRS_ADDR_INTCTL, 8'hc0);
    push(1'b1);
    wr(CIRS_ADDR_PREQ1, 8'h00);
    wr(CIRS_ADDR_INTCTL, 8'h04);
    rdc(CIRS_ADDR_INTCTL, 8'h04);
    wr(CIRS_ADDR_INTCTL, 8'h00);
    rdc(CIRS_ADDR_INTCTL, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      wr(CIRS_ADDR_PEN2, r);
      rdc(CIRS_ADDR_PEN2, r & CIRS_PREQ2_MASK);
      wr(CIRS_ADDR_PREQ1, 8'h00);
      wr(CIRS_ADDR_PREQ2, 8'h00);
      preq1 <= r;
      preq2 <= ~r;
      @(posedge sys_clk);
      preq1 <= 8'h00;
      preq2 <= 8'h00;
      rdc(CIRS_ADDR_PREQ1, r & CIRS_PREQ1_MASK);
      rdc(CIRS_ADDR_PREQ2, ~r & CIRS_PREQ2_MASK);
    end
    wr(CIRS_ADDR_POWER_CONTROL_FLAGS, 8'h06);
    wr(CIRS_ADDR_INTCTL, 8'h80);
    ev(0);
    rdc(CIRS_ADDR_INTCTL, 8'h00);
    rd(CIRS_ADDR_POWER_CONTROL_FLAGS);
    chk({7'h00, got[1]}, 8'h00);
    chk(got, 8'h04);
    rd(CIRS_ADDR_STATUS);
    chk({3'h0, got[7:3]}, 8'h03);
    finish_test();
  end
endmodule : cirs_core_tb
